//--- rtl/dtc_pkg.sv
// constants, register map and mode encodings for the dual timer control
// assumes an 8-bit cpu-style register port with 16-bit byte addresses
`default_nettype none
package dtc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_PORT2_DIR = 16'hff22;
  localparam logic [15:0] ADDR_TIMER_A_MODE = 16'hff52;
  localparam logic [15:0] ADDR_TIMER_B_MODE = 16'hff56;
  localparam logic [15:0] ADDR_CARRIER_CTRL = 16'hff57;
  localparam logic [7:0] RST_PORT2_DIR = 8'hff;
  localparam logic [7:0] RST_TIMER_MODE = 8'h00;
  localparam logic [7:0] RST_CARRIER_CTRL = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // writable bits; the rest are held at zero, or at one for port 2 direction
  localparam logic [7:0] TIMER_A_MODE_MASK = 8'hbe;
  localparam logic [7:0] TIMER_B_MODE_MASK = 8'hbf;
  localparam logic [7:0] PORT2_DIR_MASK = 8'h03;
  localparam logic [7:0] PORT2_DIR_FIXED = 8'hfc;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RUN_BIT = 7;
  localparam int CLK_SEL_HI = 5;
  localparam int CLK_SEL_LO = 3;
  localparam int MODE_HI = 2;
  localparam int MODE_LO = 1;
  localparam int OUT_ENABLE_BIT = 0;
  localparam int REMOTE_LEVEL_BIT = 2;
  localparam int NRZ_NEXT_BIT = 1;
  localparam int NRZ_CUR_BIT = 0;
  localparam int OUT_PIN_DIR_BIT = 0;
  localparam int EXT_PIN_DIR_BIT = 1;
  // ----------------------------------------------------------------
  // clock selects and prescaler taps
  // ----------------------------------------------------------------
  localparam logic [2:0] A_SEL_DIV64 = 3'h0;
  localparam logic [2:0] A_SEL_DIV256 = 3'h1;
  localparam logic [2:0] A_SEL_B_MATCH = 3'h2;
  localparam logic [2:0] A_SEL_CARRIER = 3'h3;
  localparam logic [2:0] B_SEL_SYS = 3'h0;
  localparam logic [2:0] B_SEL_DIV4 = 3'h1;
  localparam logic [2:0] B_SEL_EXT1 = 3'h2;
  localparam logic [2:0] B_SEL_EXT2 = 3'h3;
  localparam logic [2:0] B_SEL_EXT4 = 3'h4;
  localparam logic [2:0] B_SEL_EXT8 = 3'h5;
  localparam logic [7:0] PRE_DIV4_TAP = 8'h03;
  localparam logic [7:0] PRE_DIV64_TAP = 8'h3f;
  localparam logic [7:0] PRE_DIV256_TAP = 8'hff;
  localparam logic [2:0] EXT_DIV2_TAP = 3'h1;
  localparam logic [2:0] EXT_DIV4_TAP = 3'h3;
  localparam logic [2:0] EXT_DIV8_TAP = 3'h7;
  // ----------------------------------------------------------------
  // joint mode code {timer a mode, timer b mode}
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_CODE_DISCRETE = 4'h0;
  localparam logic [3:0] MODE_CODE_CASCADE = 4'h5;
  localparam logic [3:0] MODE_CODE_CARRIER = 4'h3;
  localparam logic [3:0] MODE_CODE_PWM = 4'h2;
  typedef enum logic [2:0] {
    DTC_DISCRETE = 3'b000,
    DTC_CASCADE = 3'b001,
    DTC_CARRIER = 3'b011,
    DTC_PWM = 3'b010,
    DTC_PROHIBITED = 3'b110
  } dtc_mode_t;
endpackage
`default_nettype wire

//--- rtl/dtc_sync2.sv
// two-flop synchroniser for a level arriving from a pin
// assumes the input is asynchronous to clk_sys
`default_nettype none
module dtc_sync2 (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_q;

  // first flop feeds only the second
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- rtl/dtc_up_counter.sv
// up counter with synchronous clear and count enable
// assumes tick is a one-cycle enable on clk_sys
`default_nettype none
module dtc_up_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic tick,
  output logic [WIDTH-1:0] count,
  output logic carry
);
  // refuse a width the counter cannot serve
  if (WIDTH < 1) begin : g_bad_width
    $error("counter width must be at least one");
  end

  // clear wins over a tick; wraps at all ones
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (tick) begin
      count <= count + 1'b1;
    end
  end

  // carry out in the cycle the counter wraps
  assign carry = tick & (&count) & ~clear;
endmodule
`default_nettype wire

//--- rtl/dtc_timer_ctrl.sv
// dual 8-bit timer control: modes, clock selection, carrier output path
// assumes compare values and the pin latch come from neighbouring logic
`default_nettype none
module dtc_timer_ctrl
  import dtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic [7:0] compareA,
  input wire logic [7:0] compareBLowWidth,
  input wire logic [7:0] compareBHighWidth,
  input wire logic outPinLatch,
  input wire logic extPinLatch,
  input wire logic externalCountPin,
  output logic [7:0] counterA,
  output logic [7:0] counterB,
  output logic timerAMatchIrq,
  output logic timerBMatchIrq,
  output logic timerOutputPin,
  output logic timerOutputPinOe,
  output logic extClkPinOut,
  output logic extClkPinOe
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] timerAModeCtrl_q;
  logic [7:0] timerBModeCtrl_q;
  logic [7:0] port2Direction_q;
  logic remoteLevelSelect_q;
  logic nrzNextBuffer_q;
  logic nrzCurrentBit_q;
  logic carrierHigh_q;
  logic squareWave_q;
  logic extSync;
  logic extSyncDly_q;
  logic [7:0] prescale;
  logic [2:0] extDiv;
  logic [7:0] cntA;
  logic [7:0] cntB;
  logic carryB;
  logic runBDly_q;
  dtc_mode_t mode;
  logic wrTimerA, wrTimerB, wrPort2, wrCarrier;
  logic [2:0] selA, selB;
  logic runA, runB, timerOutEnable;
  logic extEdge, tickB, tickA;
  logic matchCondB, matchCondA, matchB, matchA, carrierRise;
  logic clearA, clearB, timerOut;

  assign wrTimerA = regWrEn && (regAddr == ADDR_TIMER_A_MODE);
  assign wrTimerB = regWrEn && (regAddr == ADDR_TIMER_B_MODE);
  assign wrPort2 = regWrEn && (regAddr == ADDR_PORT2_DIR);
  assign wrCarrier = regWrEn && (regAddr == ADDR_CARRIER_CTRL);

  // mode registers; reserved bits are held at zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      timerAModeCtrl_q <= RST_TIMER_MODE;
      timerBModeCtrl_q <= RST_TIMER_MODE;
    end else begin
      if (wrTimerA) begin
        timerAModeCtrl_q <= regWrData & TIMER_A_MODE_MASK;
      end
      if (wrTimerB) begin
        timerBModeCtrl_q <= regWrData & TIMER_B_MODE_MASK;
      end
    end
  end

  // port 2 direction, upper bits fixed at one
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port2Direction_q <= RST_PORT2_DIR;
    end else if (wrPort2) begin
      port2Direction_q <= (regWrData & PORT2_DIR_MASK) | PORT2_DIR_FIXED;
    end
  end

  // carrier output control: remote level and next buffer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      remoteLevelSelect_q <= RST_CARRIER_CTRL[REMOTE_LEVEL_BIT];
      nrzNextBuffer_q <= RST_CARRIER_CTRL[NRZ_NEXT_BIT];
    end else if (wrCarrier) begin
      remoteLevelSelect_q <= regWrData[REMOTE_LEVEL_BIT];
      nrzNextBuffer_q <= regWrData[NRZ_NEXT_BIT];
    end else if (runBDly_q && !runB) begin
      nrzNextBuffer_q <= 1'b0;
    end
  end

  // current nrz bit: transfer on match wins over a write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      nrzCurrentBit_q <= RST_CARRIER_CTRL[NRZ_CUR_BIT];
    end else if (matchA) begin
      nrzCurrentBit_q <= nrzNextBuffer_q;
    end else if (wrCarrier && !timerOutEnable) begin
      nrzCurrentBit_q <= regWrData[NRZ_CUR_BIT];
    end
  end

  // read port; carrier control is write only and reads as zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= RD_UNMAPPED;
    end else if (regRdEn) begin
      case (regAddr)
        ADDR_TIMER_A_MODE: regRdData <= timerAModeCtrl_q;
        ADDR_TIMER_B_MODE: regRdData <= timerBModeCtrl_q;
        ADDR_PORT2_DIR: regRdData <= port2Direction_q;
        default: regRdData <= RD_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // mode decode and run control
  // ----------------------------------------------------------------
  always_comb begin
    case ({timerAModeCtrl_q[MODE_HI:MODE_LO],
           timerBModeCtrl_q[MODE_HI:MODE_LO]})
      MODE_CODE_DISCRETE: mode = DTC_DISCRETE;
      MODE_CODE_CASCADE: mode = DTC_CASCADE;
      MODE_CODE_CARRIER: mode = DTC_CARRIER;
      MODE_CODE_PWM: mode = DTC_PWM;
      default: mode = DTC_PROHIBITED;
    endcase
  end

  assign selA = timerAModeCtrl_q[CLK_SEL_HI:CLK_SEL_LO];
  assign selB = timerBModeCtrl_q[CLK_SEL_HI:CLK_SEL_LO];
  assign timerOutEnable = timerBModeCtrl_q[OUT_ENABLE_BIT];
  assign runB = timerBModeCtrl_q[RUN_BIT] && (mode != DTC_PROHIBITED);
  // cascade hands timer a's run control to timer b
  assign runA = (mode == DTC_CASCADE) ? runB :
                (timerAModeCtrl_q[RUN_BIT] && (mode != DTC_PROHIBITED));

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      runBDly_q <= 1'b0;
    end else begin
      runBDly_q <= runB;
    end
  end

  // ----------------------------------------------------------------
  // count clock generation
  // ----------------------------------------------------------------
  dtc_up_counter #(.WIDTH(8)) u_prescale (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clear(1'b0),
    .tick(1'b1),
    .count(prescale),
    .carry()
  );

  dtc_sync2 u_ext_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .asyncIn(externalCountPin),
    .syncOut(extSync)
  );

  // rising edge of the synchronised external clock
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      extSyncDly_q <= 1'b0;
    end else begin
      extSyncDly_q <= extSync;
    end
  end
  assign extEdge = extSync & ~extSyncDly_q;

  dtc_up_counter #(.WIDTH(3)) u_ext_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clear(1'b0),
    .tick(extEdge),
    .count(extDiv),
    .carry()
  );

  // timer b count enable
  always_comb begin
    case (selB)
      B_SEL_SYS: tickB = 1'b1;
      B_SEL_DIV4: tickB = (prescale[1:0] == PRE_DIV4_TAP[1:0]);
      B_SEL_EXT1: tickB = extEdge;
      B_SEL_EXT2: tickB = extEdge && (extDiv[0] == EXT_DIV2_TAP[0]);
      B_SEL_EXT4: tickB = extEdge && (extDiv[1:0] == EXT_DIV4_TAP[1:0]);
      B_SEL_EXT8: tickB = extEdge && (extDiv == EXT_DIV8_TAP);
      default: tickB = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // counters and match
  // ----------------------------------------------------------------
  always_comb begin
    if (mode == DTC_CARRIER || mode == DTC_PWM) begin
      matchCondB = (cntB == (carrierHigh_q ? compareBHighWidth :
                             compareBLowWidth));
    end else if (mode == DTC_CASCADE) begin
      matchCondB = (cntB == compareBLowWidth) && (cntA == compareA);
    end else begin
      matchCondB = (cntB == compareBLowWidth);
    end
  end
  assign matchB = runB && tickB && matchCondB;
  assign carrierRise = matchB && !carrierHigh_q;

  // timer a count enable; cascade forces the timer b carry
  always_comb begin
    if (mode == DTC_CASCADE) begin
      tickA = carryB && !matchB;
    end else begin
      case (selA)
        A_SEL_DIV64: tickA = (prescale[5:0] == PRE_DIV64_TAP[5:0]);
        A_SEL_DIV256: tickA = (prescale == PRE_DIV256_TAP);
        A_SEL_B_MATCH: tickA = matchB;
        A_SEL_CARRIER: tickA = carrierRise;
        default: tickA = 1'b0;
      endcase
    end
  end
  assign matchCondA = (cntA == compareA) && (mode != DTC_CASCADE);
  assign matchA = runA && tickA && matchCondA;

  assign clearB = !runB || matchB;
  assign clearA = !runA || matchA ||
                  ((mode == DTC_CASCADE) && matchB);

  dtc_up_counter #(.WIDTH(8)) u_counter_a (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clear(clearA),
    .tick(tickA),
    .count(cntA),
    .carry()
  );

  dtc_up_counter #(.WIDTH(8)) u_counter_b (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clear(clearB),
    .tick(tickB),
    .count(cntB),
    .carry(carryB)
  );

  // carrier phase toggles on each width match; square wave on match
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      carrierHigh_q <= 1'b0;
      squareWave_q <= 1'b0;
    end else if (!runB) begin
      carrierHigh_q <= 1'b0;
      squareWave_q <= 1'b0;
    end else if (matchB) begin
      carrierHigh_q <= ~carrierHigh_q;
      squareWave_q <= ~squareWave_q;
    end
  end

  // ----------------------------------------------------------------
  // timer output path and pins
  // ----------------------------------------------------------------
  always_comb begin
    case (mode)
      DTC_CARRIER: timerOut = nrzCurrentBit_q &&
                   (remoteLevelSelect_q || carrierHigh_q);
      DTC_PWM: timerOut = carrierHigh_q;
      DTC_DISCRETE, DTC_CASCADE: timerOut = squareWave_q;
      default: timerOut = 1'b0;
    endcase
  end

  // registered outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      counterA <= 8'h00;
      counterB <= 8'h00;
      timerAMatchIrq <= 1'b0;
      timerBMatchIrq <= 1'b0;
      timerOutputPin <= 1'b0;
      timerOutputPinOe <= 1'b0;
      extClkPinOut <= 1'b0;
      extClkPinOe <= 1'b0;
    end else begin
      counterA <= cntA;
      counterB <= cntB;
      timerAMatchIrq <= matchA;
      timerBMatchIrq <= matchB;
      timerOutputPin <= outPinLatch | (timerOutEnable & timerOut);
      timerOutputPinOe <= ~port2Direction_q[OUT_PIN_DIR_BIT];
      extClkPinOut <= extPinLatch;
      extClkPinOe <= ~port2Direction_q[EXT_PIN_DIR_BIT];
    end
  end
endmodule
`default_nettype wire

//--- sim/dtc_timer_ctrl_props.sv
// concurrent checks on the dual timer control ports
// assumes the simple strobe register port and one clock domain
`default_nettype none
module dtc_timer_ctrl_props
  import dtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic [7:0] compareBLowWidth,
  input wire logic outPinLatch,
  input wire logic [7:0] counterA,
  input wire logic [7:0] counterB,
  input wire logic timerOutputPin,
  input wire logic timerOutputPinOe,
  input wire logic extClkPinOe
);
  // ----------------------------------------------------------------
  // shadow copies of the mode registers
  // ----------------------------------------------------------------
  logic [7:0] aMode_q;
  logic [7:0] bMode_q;
  logic cascade;
  logic discrete;
  // follow host writes to both mode registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aMode_q <= 8'h00;
      bMode_q <= 8'h00;
    end else if (regWrEn && regAddr == ADDR_TIMER_A_MODE) begin
      aMode_q <= regWrData & TIMER_A_MODE_MASK;
    end else if (regWrEn && regAddr == ADDR_TIMER_B_MODE) begin
      bMode_q <= regWrData & TIMER_B_MODE_MASK;
    end
  end
  // joint mode decode
  assign cascade = {aMode_q[2:1], bMode_q[2:1]} == MODE_CODE_CASCADE;
  assign discrete = {aMode_q[2:1], bMode_q[2:1]} == MODE_CODE_DISCRETE;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  a_carrier_read_zero: assert property (
    regRdEn && regAddr == ADDR_CARRIER_CTRL |=> regRdData == 8'h00)
    else $error("carrier control read not zero");
  a_dir_upper_ones: assert property (
    regRdEn && regAddr == ADDR_PORT2_DIR |=> regRdData[7:2] == 6'h3f)
    else $error("direction upper bits not one");
  a_out_oe_dir: assert property (
    regWrEn && regAddr == ADDR_PORT2_DIR
    |-> ##3 timerOutputPinOe == !$past(regWrData[0], 3))
    else $error("timer pin enable does not follow direction");
  a_ext_oe_dir: assert property (
    regWrEn && regAddr == ADDR_PORT2_DIR
    |-> ##3 extClkPinOe == !$past(regWrData[1], 3))
    else $error("clock pin enable does not follow direction");
  a_b_halt_clear: assert property (
    (!bMode_q[7]) [*4] |-> counterB == 8'h00)
    else $error("counter b not cleared while halted");
  a_cascade_a_clear: assert property (
    (!bMode_q[7] && cascade) [*4] |-> counterA == 8'h00)
    else $error("counter a not cleared with timer b halted");
  a_a_halt_clear: assert property (
    (!aMode_q[7] && !cascade) [*4] |-> counterA == 8'h00)
    else $error("counter a not cleared while halted");
  a_pin_oe_gate: assert property (
    (!bMode_q[0] && !outPinLatch) [*4] |-> !timerOutputPin)
    else $error("timer pin driven while output disabled");
  a_b_sys_step: assert property (
    (bMode_q[7] && bMode_q[5:3] == B_SEL_SYS && discrete &&
     compareBLowWidth == 8'hff) [*5]
    |-> counterB == $past(counterB) + 8'h01)
    else $error("counter b misses a system clock tick");
  a_cascade_a_step: assert property (
    (cascade && bMode_q[7]) [*3] ##0 $changed(counterA)
    |-> counterB <= 8'h01)
    else $error("counter a moved without a timer b wrap");
  a_b_mode_read: assert property (
    regRdEn && regAddr == ADDR_TIMER_B_MODE |=> regRdData == $past(bMode_q))
    else $error("timer b mode read back wrong");
  // main scenarios reached
  c_cascade_run: cover property (cascade && bMode_q[7] && counterA != 8'h00);
  c_pin_high: cover property (bMode_q[0] && timerOutputPin);
  c_carrier_read: cover property (regRdEn && regAddr == ADDR_CARRIER_CTRL);
endmodule

bind dtc_timer_ctrl dtc_timer_ctrl_props i_props (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regWrEn(regWrEn),
  .regRdEn(regRdEn),
  .regRdData(regRdData),
  .compareBLowWidth(compareBLowWidth),
  .outPinLatch(outPinLatch),
  .counterA(counterA),
  .counterB(counterB),
  .timerOutputPin(timerOutputPin),
  .timerOutputPinOe(timerOutputPinOe),
  .extClkPinOe(extClkPinOe)
);
`default_nettype wire

//--- sim/dtc_timer_ctrl_tb.sv
// self-checking bench for the dual timer control
// assumes the strobe register port, inputs driven on the falling edge
`default_nettype none
module dtc_timer_ctrl_tb
  import dtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // stimulus signals and bookkeeping
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regRdData;
  logic [7:0] compareA = 8'hff;
  logic [7:0] compareBLowWidth = 8'hff;
  logic [7:0] compareBHighWidth = 8'hff;
  logic externalCountPin = 1'b0;
  logic outPinLatch = 1'b0;
  logic extPinLatch = 1'b0;
  logic [2:0] extPh = 3'h0;
  logic [7:0] counterA, counterB, diff;
  logic timerAMatchIrq, timerBMatchIrq, timerOutputPin, timerOutputPinOe;
  logic extClkPinOut, extClkPinOe, hi, lo, irqA, irqB;
  int miscompares = 0;
  int comparisons = 0;
  int bDiv[6] = '{1, 4, 8, 16, 32, 64};
  int aDiv[4] = '{64, 256, 16, 32};
  dtc_timer_ctrl i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .compareA(compareA),
    .compareBLowWidth(compareBLowWidth), .compareBHighWidth(compareBHighWidth),
    .outPinLatch(outPinLatch), .extPinLatch(extPinLatch),
    .externalCountPin(externalCountPin), .counterA(counterA),
    .counterB(counterB), .timerAMatchIrq(timerAMatchIrq),
    .timerBMatchIrq(timerBMatchIrq), .timerOutputPin(timerOutputPin),
    .timerOutputPinOe(timerOutputPinOe), .extClkPinOut(extClkPinOut),
    .extClkPinOe(extClkPinOe));
  // clock and an external count clock of eight system periods
  always #20 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    extPh <= extPh + 3'h1;
    externalCountPin <= extPh[2];
  end
  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk_sys);
    regWrEn = 1'b0;
  endtask
  task automatic rdc(input string n, input logic [15:0] a,
                     input logic [7:0] e);
    @(negedge clk_sys);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk_sys);
    regRdEn = 1'b0;
    @(negedge clk_sys);
    chk8(n, e, regRdData);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // counter advance over a window of n cycles
  task automatic span(input bit selA, input int n, output logic [7:0] d);
    logic [7:0] s;
    @(negedge clk_sys);
    s = selA ? counterA : counterB;
    repeat (n) @(negedge clk_sys);
    d = (selA ? counterA : counterB) - s;
  endtask
  task automatic pinAll(input string n, input logic v);
    logic good;
    good = 1'b1;
    repeat (16) begin
      @(negedge clk_sys);
      if (timerOutputPin !== v) good = 1'b0;
    end
    chk1(n, 1'b1, good);
  endtask
  // note which pin levels and match pulses appear over n cycles
  task automatic watch(input int n, output logic h, output logic l,
                       output logic ia, output logic ib);
    h = 1'b0;
    l = 1'b0;
    ia = 1'b0;
    ib = 1'b0;
    repeat (n) begin
      @(negedge clk_sys);
      if (timerOutputPin === 1'b1) h = 1'b1;
      if (timerOutputPin === 1'b0) l = 1'b1;
      if (timerAMatchIrq === 1'b1) ia = 1'b1;
      if (timerBMatchIrq === 1'b1) ib = 1'b1;
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run length
  initial begin
    #2000000;
    miscompares++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    idle(2);
    rst_b = 1'b1;
    rdc("port2_dir_reset", ADDR_PORT2_DIR, 8'hff);
    rdc("a_mode_reset", ADDR_TIMER_A_MODE, 8'h00);
    rdc("b_mode_reset", ADDR_TIMER_B_MODE, 8'h00);
    rdc("carrier_reset", ADDR_CARRIER_CTRL, 8'h00);
    chk1("out_oe_reset", 1'b0, timerOutputPinOe);
    wr(ADDR_TIMER_A_MODE, 8'hbe);
    rdc("a_mode_reserved", ADDR_TIMER_A_MODE, 8'hbe);
    wr(ADDR_TIMER_A_MODE, 8'h00);
    wr(ADDR_TIMER_B_MODE, 8'h3f);
    rdc("b_mode_reserved", ADDR_TIMER_B_MODE, 8'h3f);
    wr(ADDR_TIMER_B_MODE, 8'h00);
    wr(ADDR_CARRIER_CTRL, 8'h07);
    rdc("carrier_write_only", ADDR_CARRIER_CTRL, 8'h00);
    wr(16'hff53, 8'h5a);
    rdc("unmapped", 16'hff53, 8'h00);
    wr(ADDR_PORT2_DIR, 8'h00);
    idle(4);
    chk1("out_oe_on", 1'b1, timerOutputPinOe);
    chk1("ext_oe_on", 1'b1, extClkPinOe);
    outPinLatch = 1'b1;
    extPinLatch = 1'b1;
    idle(2);
    chk1("pin_latch_or", 1'b1, timerOutputPin);
    chk1("ext_latch_out", 1'b1, extClkPinOut);
    outPinLatch = 1'b0;
    extPinLatch = 1'b0;
    rdc("port2_dir_fixed", ADDR_PORT2_DIR, 8'hfc);
    for (int s = 0; s < 6; s++) begin
      wr(ADDR_TIMER_B_MODE, 8'h00);
      wr(ADDR_TIMER_B_MODE, {2'b10, 3'(s), 3'b000});
      idle(8);
      span(1'b0, 1600, diff);
      chk8("b_clock_select", 8'(1600 / bDiv[s]), diff);
    end
    compareBLowWidth = 8'h0f;
    wr(ADDR_TIMER_B_MODE, 8'h80);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_TIMER_A_MODE, 8'h00);
      wr(ADDR_TIMER_A_MODE, {2'b10, 3'(s), 3'b000});
      idle(8);
      span(1'b1, 1024, diff);
      chk8("a_clock_select", 8'(1024 / aDiv[s]), diff);
    end
    wr(ADDR_TIMER_A_MODE, 8'h00);
    idle(4);
    chk8("a_halt_clear", 8'h00, counterA);
    wr(ADDR_TIMER_B_MODE, 8'h00);
    compareBLowWidth = 8'hff;
    wr(ADDR_TIMER_A_MODE, 8'h02);
    wr(ADDR_TIMER_B_MODE, 8'h82);
    idle(8);
    span(1'b1, 1024, diff);
    chk8("cascade_a_count", 8'h04, diff);
    wr(ADDR_TIMER_B_MODE, 8'h02);
    idle(4);
    chk8("cascade_a_clear", 8'h00, counterA);
    chk8("cascade_b_clear", 8'h00, counterB);
    wr(ADDR_TIMER_A_MODE, 8'h00);
    compareBLowWidth = 8'h03;
    compareBHighWidth = 8'h03;
    wr(ADDR_CARRIER_CTRL, 8'h05);
    wr(ADDR_TIMER_B_MODE, 8'h87);
    idle(4);
    pinAll("pin_remote_high", 1'b1);
    wr(ADDR_CARRIER_CTRL, 8'h04);
    idle(4);
    pinAll("pin_nrz_locked", 1'b1);
    wr(ADDR_TIMER_B_MODE, 8'h86);
    idle(4);
    pinAll("pin_output_off", 1'b0);
    wr(ADDR_CARRIER_CTRL, 8'h04);
    wr(ADDR_TIMER_B_MODE, 8'h87);
    idle(4);
    pinAll("pin_nrz_low", 1'b0);
    wr(ADDR_CARRIER_CTRL, 8'h06);
    compareA = 8'h00;
    wr(ADDR_TIMER_A_MODE, 8'h80);
    watch(200, hi, lo, irqA, irqB);
    chk1("pin_nrz_load", 1'b1, hi);
    chk1("a_match_irq", 1'b1, irqA);
    wr(ADDR_CARRIER_CTRL, 8'h02);
    idle(4);
    watch(40, hi, lo, irqA, irqB);
    chk1("pin_carrier_toggles", 1'b1, hi & lo);
    chk1("b_match_irq", 1'b1, irqB);
    wr(ADDR_TIMER_B_MODE, 8'h85);
    idle(4);
    watch(40, hi, lo, irqA, irqB);
    chk1("pwm_toggles", 1'b1, hi & lo);
    wr(ADDR_TIMER_B_MODE, 8'h00);
    wr(ADDR_TIMER_A_MODE, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
